// ---- core/fpc_pkg.sv ----
package fpc_pkg;
  // ----------------------------------------
  // widths and counts
  // ----------------------------------------
  localparam int DATA_W = 16;
  localparam int ACC_W = 40;
  localparam int PROD_W = 32;
  localparam int UPPER_DATA_W = 8;
  localparam int NUM_DREG = 16;
  localparam int DREG_IDX_W = 4;
  localparam int LEGACY_IDX_W = 3;
  localparam int SHIFT_W = 6;

  // ----------------------------------------
  // data register file index map
  // ----------------------------------------
  localparam logic [3:0] REG_AR_IDX = 4'h9;
  localparam logic [3:0] REG_MR0_IDX = 4'hA;
  localparam logic [3:0] REG_MR1_IDX = 4'hB;
  localparam logic [3:0] REG_MR2_IDX = 4'hC;
  localparam logic [3:0] REG_SR0_IDX = 4'hD;
  localparam logic [3:0] REG_SR1_IDX = 4'hE;
  localparam logic [3:0] REG_SR2_IDX = 4'hF;

  // ----------------------------------------
  // mode control and flag layout
  // ----------------------------------------
  localparam int MODE_W = 8;
  localparam int MODE_INT_MULT_BIT = 4;
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam int FLAGS_W = 8;
  localparam int FLAG_ZERO_BIT = 0;
  localparam int FLAG_NEG_BIT = 1;
  localparam int FLAG_OVF_BIT = 2;
  localparam int FLAG_CARRY_BIT = 3;
  localparam int FLAG_SHIFT_SIGN_BIT = 4;
  localparam int FLAG_MULT_OVF_BIT = 5;
  localparam logic [7:0] FLAGS_RESET = 8'h00;

  // ----------------------------------------
  // APB register map
  // ----------------------------------------
  localparam logic [7:0] ADDR_MODE = 8'h00;
  localparam logic [7:0] ADDR_FLAGS = 8'h04;
  localparam logic [7:0] ADDR_BANK = 8'h08;
  localparam logic [7:0] ADDR_BLOCK_EXP = 8'h0C;
  localparam logic [7:0] ADDR_SHIFT_EXP = 8'h10;

  typedef enum logic [3:0] {
    OP_NOP, OP_ADD, OP_SUB, OP_AND, OP_OR, OP_XOR, OP_NOT, OP_SIGNED_DIVIDE_STEP,
    OP_MUL, OP_MAC, OP_MSUB, OP_LSHIFT, OP_ASHIFT, OP_EXP, OP_MOVE, OP_MOVE_EXP
  } fpc_op_t;

  typedef enum logic [1:0] {
    DST_ALU_RESULT, DST_ALU_FEEDBACK, DST_MULT_ACC, DST_SHIFT_ACC
  } fpc_dst_t;

  typedef struct packed {
    logic valid;
    fpc_op_t op;
    fpc_dst_t dst;
    logic conditional;
    logic multifunction;
    logic [3:0] x_idx;
    logic [3:0] y_idx;
    logic [3:0] move_dst_idx;
    logic x_signed;
    logic y_signed;
    logic round;
    logic use_feedback;
    logic exp_sel_shift;
    logic exp_to_reg;
  } fpc_instr_t;
endpackage : fpc_pkg

// ---- core/fpc_compute.sv ----
`timescale 1ns/10ps
module fpc_compute (
  // clock and reset
  input wire logic CLOCK_IN,
  input wire logic RST_N_IN,
  // instruction from sequencer
  input wire fpc_pkg::fpc_instr_t INSTR_IN,
  input wire logic [15:0] SHIFT_AMT_IN,
  input wire logic [3:0] LOAD_IDX_IN,
  input wire logic LOAD_EN_IN,
  input wire logic [15:0] LOAD_DATA_IN,
  input wire logic [3:0] READ_IDX_IN,
  // APB slave
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [7:0] PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  output logic [31:0] PRDATA_OUT,
  output logic PREADY_OUT,
  output logic PSLVERR_OUT,
  // status
  output logic [15:0] READ_DATA_OUT,
  output logic [39:0] MULT_ACC_OUT,
  output logic [39:0] SHIFT_ACC_OUT,
  output logic ILLEGAL_OPERAND_OUT
);
  // ----------------------------------------
  // state
  // ----------------------------------------
  logic [15:0] dreg_reg [2][16];
  logic [15:0] feedback_reg [2];
  logic [15:0] block_exp_reg [2];
  logic [15:0] shift_exp_reg [2];
  logic bank_reg;
  logic [7:0] mode_control_reg;
  logic [7:0] arith_flags_reg;

  fpc_pkg::fpc_instr_t ins;
  assign ins = INSTR_IN;

  // ----------------------------------------
  // operand fetch
  // ----------------------------------------
  // conditional/multifunction opcodes carry only three index bits
  wire restricted = ins.conditional | ins.multifunction;
  wire [3:0] x_sel = restricted ? {1'b0, ins.x_idx[2:0]} : ins.x_idx;
  wire [3:0] y_sel = restricted ? {1'b0, ins.y_idx[2:0]} : ins.y_idx;
  wire illegal = ins.valid & restricted & (ins.x_idx[3] | ins.y_idx[3]);
  // upper words are read with all 16 bits
  wire [15:0] xop = dreg_reg[bank_reg][x_sel];
  wire [15:0] yraw = dreg_reg[bank_reg][y_sel];
  wire [15:0] yop = ins.use_feedback ? feedback_reg[bank_reg] : yraw;

  // ----------------------------------------
  // ALU
  // ----------------------------------------
  // bit patterns only; flags give the signed view
  wire [16:0] add_sum = {1'b0, xop} + {1'b0, yop};
  wire [16:0] sub_sum = {1'b0, xop} + {1'b0, ~yop} + 17'h00001;
  wire is_sub = (ins.op == fpc_pkg::OP_SUB) | (ins.op == fpc_pkg::OP_SIGNED_DIVIDE_STEP);
  wire [16:0] arith = is_sub ? sub_sum : add_sum;
  // divide step: quotient sign is the only signed interpretation
  wire signed_divide_step_q = xop[15] ^ yop[15];
  logic [15:0] alu_res;
  always_comb begin
    case (ins.op)
      fpc_pkg::OP_AND: alu_res = xop & yop;
      fpc_pkg::OP_OR: alu_res = xop | yop;
      fpc_pkg::OP_XOR: alu_res = xop ^ yop;
      fpc_pkg::OP_NOT: alu_res = ~xop;
      fpc_pkg::OP_SIGNED_DIVIDE_STEP: alu_res = {xop[14:0], signed_divide_step_q};
      default: alu_res = arith[15:0];
    endcase
  end
  wire alu_arith = (ins.op == fpc_pkg::OP_ADD) | (ins.op == fpc_pkg::OP_SUB);
  wire alu_logic = (ins.op == fpc_pkg::OP_AND) | (ins.op == fpc_pkg::OP_OR) |
                   (ins.op == fpc_pkg::OP_XOR) | (ins.op == fpc_pkg::OP_NOT) |
                   (ins.op == fpc_pkg::OP_SIGNED_DIVIDE_STEP);
  wire y_eff_sign = is_sub ? ~yop[15] : yop[15];
  // same-sign inputs with a flipped result sign is overflow
  wire alu_overflow_flag = alu_arith & (xop[15] == y_eff_sign) &
                           (alu_res[15] != xop[15]);
  wire alu_carry_flag = alu_arith & arith[16];
  wire alu_negative_flag = alu_res[15];

  // ----------------------------------------
  // multiplier
  // ----------------------------------------
  wire signed [16:0] xm = {ins.x_signed & xop[15], xop};
  wire signed [16:0] ym = {ins.y_signed & yop[15], yop};
  wire signed [33:0] prod_full = xm * ym;
  wire [31:0] prod = prod_full[31:0];
  wire int_mode = mode_control_reg[fpc_pkg::MODE_INT_MULT_BIT];
  // fractional: 2.30 becomes 1.31, lsb zero filled
  wire [31:0] prod_adj = int_mode ? prod : {prod[30:0], 1'b0};
  wire [39:0] prod_ext = {{8{prod_adj[31]}}, prod_adj};
  wire [39:0] acc_old = (ins.dst == fpc_pkg::DST_SHIFT_ACC) ?
    {dreg_reg[bank_reg][fpc_pkg::REG_SR2_IDX][7:0], dreg_reg[bank_reg][fpc_pkg::REG_SR1_IDX],
     dreg_reg[bank_reg][fpc_pkg::REG_SR0_IDX]} :
    {dreg_reg[bank_reg][fpc_pkg::REG_MR2_IDX][7:0], dreg_reg[bank_reg][fpc_pkg::REG_MR1_IDX],
     dreg_reg[bank_reg][fpc_pkg::REG_MR0_IDX]};
  logic [39:0] mac_sum;
  always_comb begin
    case (ins.op)
      fpc_pkg::OP_MAC: mac_sum = acc_old + prod_ext;
      fpc_pkg::OP_MSUB: mac_sum = acc_old - prod_ext;
      default: mac_sum = prod_ext;
    endcase
  end
  // simple round-to-nearest at the 16-bit boundary
  wire [39:0] mac_res = ins.round ? ((mac_sum + 40'h0000008000) & 40'hFFFFFF0000) : mac_sum;
  wire mult_ovf = ~((mac_res[39:31] == 9'h000) | (mac_res[39:31] == 9'h1FF));

  // ----------------------------------------
  // shifter
  // ----------------------------------------
  wire [15:0] sh_amt = ins.exp_sel_shift ? shift_exp_reg[bank_reg] : SHIFT_AMT_IN;
  wire signed [5:0] amt = sh_amt[5:0];
  wire [5:0] amt_mag = amt[5] ? 6'(-amt) : amt;
  wire signed [39:0] sh_in = {{24{xop[15]}}, xop};
  wire [39:0] u_in = {24'h000000, xop};
  logic [39:0] shift_res;
  always_comb begin
    if (ins.op == fpc_pkg::OP_LSHIFT) begin
      shift_res = amt[5] ? (u_in >> amt_mag) : (u_in << amt_mag);
    end else begin
      shift_res = amt[5] ? 40'(sh_in >>> amt_mag) : 40'(sh_in <<< amt_mag);
    end
  end
  // exponent: count of redundant sign bits, negated
  logic [4:0] lead;
  always_comb begin
    lead = 5'h00;
    for (int i = 14; i >= 0; i--) begin
      if (xop[i] != xop[15]) begin
        lead = 5'(14 - i);
        break;
      end
    end
    if (lead == 5'h00 && xop[14] == xop[15]) lead = 5'h0F;
  end
  wire [15:0] exp_val = 16'(-$signed({11'h000, lead}));
  // block exponent keeps the largest magnitude seen (smallest lead)
  wire [15:0] blk_next = ($signed(exp_val) > $signed(block_exp_reg[bank_reg])) ?
                         exp_val : block_exp_reg[bank_reg];

  // ----------------------------------------
  // writeback
  // ----------------------------------------
  wire is_alu = alu_arith | alu_logic;
  wire is_mul = (ins.op == fpc_pkg::OP_MUL) | (ins.op == fpc_pkg::OP_MAC) |
                (ins.op == fpc_pkg::OP_MSUB);
  wire is_shift = (ins.op == fpc_pkg::OP_LSHIFT) | (ins.op == fpc_pkg::OP_ASHIFT);
  wire do_op = ins.valid & ~illegal;
  wire [3:0] a0 = (ins.dst == fpc_pkg::DST_SHIFT_ACC) ? fpc_pkg::REG_SR0_IDX :
                  fpc_pkg::REG_MR0_IDX;
  wire [39:0] wr_acc = is_mul ? mac_res : shift_res;
  wire [7:0] apb_mode = PWDATA_IN[7:0];
  wire apb_wr = PSEL_IN & PENABLE_IN & PWRITE_IN;
  // moves never name the feedback register: it has no index
  wire [15:0] move_src = (ins.op == fpc_pkg::OP_MOVE_EXP) ?
    (ins.exp_sel_shift ? shift_exp_reg[bank_reg] : block_exp_reg[bank_reg]) : xop;

  always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      for (int b = 0; b < 2; b++) begin
        for (int r = 0; r < fpc_pkg::NUM_DREG; r++) dreg_reg[b][r] <= 16'h0000;
        feedback_reg[b] <= 16'h0000;
        block_exp_reg[b] <= 16'h0000;
        shift_exp_reg[b] <= 16'h0000;
      end
      bank_reg <= 1'b0;
      mode_control_reg <= fpc_pkg::MODE_RESET;
      arith_flags_reg <= fpc_pkg::FLAGS_RESET;
    end else begin
      if (LOAD_EN_IN) dreg_reg[bank_reg][LOAD_IDX_IN] <= LOAD_DATA_IN;
      if (do_op && is_alu) begin
        if (ins.dst == fpc_pkg::DST_ALU_FEEDBACK) feedback_reg[bank_reg] <= alu_res;
        else dreg_reg[bank_reg][fpc_pkg::REG_AR_IDX] <= alu_res;
        arith_flags_reg[fpc_pkg::FLAG_ZERO_BIT] <= (alu_res == 16'h0000);
        arith_flags_reg[fpc_pkg::FLAG_NEG_BIT] <= alu_negative_flag;
        arith_flags_reg[fpc_pkg::FLAG_OVF_BIT] <= alu_overflow_flag;
        arith_flags_reg[fpc_pkg::FLAG_CARRY_BIT] <= alu_carry_flag;
      end
      if (do_op && (is_mul || is_shift)) begin
        dreg_reg[bank_reg][a0] <= wr_acc[15:0];
        dreg_reg[bank_reg][a0 + 4'h1] <= wr_acc[31:16];
        dreg_reg[bank_reg][a0 + 4'h2] <= {{8{wr_acc[39]}}, wr_acc[39:32]};
        if (is_mul) arith_flags_reg[fpc_pkg::FLAG_MULT_OVF_BIT] <= mult_ovf;
        else arith_flags_reg[fpc_pkg::FLAG_SHIFT_SIGN_BIT] <= xop[15];
      end
      if (do_op && ins.op == fpc_pkg::OP_EXP) begin
        shift_exp_reg[bank_reg] <= exp_val;
        block_exp_reg[bank_reg] <= blk_next;
      end
      if (do_op && ins.op == fpc_pkg::OP_MOVE) begin
        if (ins.exp_to_reg) begin
          if (ins.exp_sel_shift) shift_exp_reg[bank_reg] <= xop;
          else block_exp_reg[bank_reg] <= xop;
        end else begin
          dreg_reg[bank_reg][ins.move_dst_idx] <= move_src;
        end
      end
      if (do_op && ins.op == fpc_pkg::OP_MOVE_EXP) dreg_reg[bank_reg][ins.move_dst_idx] <= move_src;
      if (apb_wr && PADDR_IN == fpc_pkg::ADDR_MODE) mode_control_reg <= apb_mode;
      if (apb_wr && PADDR_IN == fpc_pkg::ADDR_BANK) bank_reg <= PWDATA_IN[0];
    end
  end

  // ----------------------------------------
  // APB read side, zero wait states
  // ----------------------------------------
  wire hit_mode = PADDR_IN == fpc_pkg::ADDR_MODE;
  wire hit_flags = PADDR_IN == fpc_pkg::ADDR_FLAGS;
  wire hit_bank = PADDR_IN == fpc_pkg::ADDR_BANK;
  wire hit_bexp = PADDR_IN == fpc_pkg::ADDR_BLOCK_EXP;
  wire hit_sexp = PADDR_IN == fpc_pkg::ADDR_SHIFT_EXP;
  wire hit_any = hit_mode | hit_flags | hit_bank | hit_bexp | hit_sexp;
  wire [31:0] rd_mux = hit_mode ? {24'h000000, mode_control_reg} :
                       hit_flags ? {24'h000000, arith_flags_reg} :
                       hit_bank ? {31'h00000000, bank_reg} :
                       hit_bexp ? {16'h0000, block_exp_reg[bank_reg]} :
                       hit_sexp ? {16'h0000, shift_exp_reg[bank_reg]} : 32'h00000000;
  assign PREADY_OUT = 1'b1;
  assign PSLVERR_OUT = PSEL_IN & PENABLE_IN & ~hit_any;
  assign PRDATA_OUT = (PSEL_IN & ~PWRITE_IN) ? rd_mux : 32'h00000000;

  assign READ_DATA_OUT = dreg_reg[bank_reg][READ_IDX_IN];
  assign MULT_ACC_OUT = {dreg_reg[bank_reg][fpc_pkg::REG_MR2_IDX][7:0],
                         dreg_reg[bank_reg][fpc_pkg::REG_MR1_IDX],
                         dreg_reg[bank_reg][fpc_pkg::REG_MR0_IDX]};
  assign SHIFT_ACC_OUT = {dreg_reg[bank_reg][fpc_pkg::REG_SR2_IDX][7:0],
                          dreg_reg[bank_reg][fpc_pkg::REG_SR1_IDX],
                          dreg_reg[bank_reg][fpc_pkg::REG_SR0_IDX]};
  assign ILLEGAL_OPERAND_OUT = illegal;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge CLOCK_IN); endclocking
  default disable iff (!RST_N_IN);
  AST_UPPER_SIGNEXT: assert property (
    (do_op && is_mul && ins.dst == fpc_pkg::DST_MULT_ACC) |=>
    dreg_reg[$past(bank_reg)][fpc_pkg::REG_MR2_IDX][15:8] ==
    {8{dreg_reg[$past(bank_reg)][fpc_pkg::REG_MR2_IDX][7]}})
    else $error("upper word not sign extended");
  AST_ALU_ONE_CYCLE: assert property (
    (do_op && alu_arith && ins.dst == fpc_pkg::DST_ALU_RESULT && !LOAD_EN_IN)
    |=> dreg_reg[$past(bank_reg)][fpc_pkg::REG_AR_IDX] == $past(alu_res))
    else $error("alu result not written next cycle");
  AST_OVF_SAME_SIGN: assert property (
    (ins.op == fpc_pkg::OP_ADD && xop[15] != yop[15]) |-> !alu_overflow_flag)
    else $error("mixed sign add overflowed");
  AST_CARRY: assert property (
    (ins.op == fpc_pkg::OP_ADD) |-> alu_carry_flag == (({1'b0, xop} + {1'b0, yop}) > 17'h0FFFF))
    else $error("carry wrong");
  AST_FRAC_SHIFT: assert property (
    !int_mode |-> prod_adj[0] == 1'b0) else $error("fractional lsb not zero");
  AST_INT_NO_SHIFT: assert property (
    int_mode |-> prod_adj == prod) else $error("integer product shifted");
  AST_PROD_EXT: assert property (
    prod_ext[39:31] == {9{prod_adj[31]}}) else $error("product not sign extended");
  AST_RESTRICT: assert property (
    restricted |-> !x_sel[3] && !y_sel[3]) else $error("restricted op reached upper bank");
  AST_FLAGS_FOLLOW: assert property (
    (do_op && alu_arith) |=> arith_flags_reg[fpc_pkg::FLAG_NEG_BIT] == $past(alu_res[15]))
    else $error("negative flag wrong");
  COV_MAC: cover property (do_op && ins.op == fpc_pkg::OP_MAC);
  COV_OVF: cover property (do_op && alu_overflow_flag);
  COV_BANK: cover property ($changed(bank_reg));
  COV_SHIFT: cover property (do_op && ins.op == fpc_pkg::OP_ASHIFT);
  COV_ILLEGAL: cover property (illegal);

  // ----------------------------------------
  // rule checks
  // ----------------------------------------
  // short decodes keep the properties readable
  wire op_add = ins.op == fpc_pkg::OP_ADD;
  wire op_sub = ins.op == fpc_pkg::OP_SUB;
  wire op_mul = ins.op == fpc_pkg::OP_MUL;
  wire op_move = ins.op == fpc_pkg::OP_MOVE;
  wire to_mr = ins.dst == fpc_pkg::DST_MULT_ACC;
  wire other_bank = ~bank_reg;

  // alu: wraparound sums, signed flags
  AST_ADD_WRAP: assert property (
    op_add |-> 16'(xop + yop) == alu_res) else $error("add result wrong");
  AST_SUB_WRAP: assert property (
    op_sub |-> 16'(alu_res + yop) == xop) else $error("sub result wrong");
  AST_SUB_OVF: assert property (
    (op_sub && xop[15] == yop[15]) |-> !alu_overflow_flag)
    else $error("like sign subtract overflowed");
  AST_ADD_OVF_POS: assert property (
    (op_add && !xop[15] && !yop[15]) |-> alu_overflow_flag == alu_res[15])
    else $error("positive add overflow wrong");
  AST_SUB_CARRY: assert property (
    op_sub |-> alu_carry_flag == (xop >= yop)) else $error("subtract carry wrong");
  AST_ZERO_FLAG: assert property (
    (do_op && is_alu) |=>
    arith_flags_reg[fpc_pkg::FLAG_ZERO_BIT] == ($past(alu_res) == 16'h0000))
    else $error("zero flag wrong");
  AST_XOR_BITWISE: assert property (
    (ins.op == fpc_pkg::OP_XOR) |-> (alu_res ^ yop) == xop) else $error("xor not bitwise");
  AST_NOT_BITWISE: assert property (
    (ins.op == fpc_pkg::OP_NOT) |-> (alu_res ^ xop) == 16'hFFFF) else $error("not wrong");

  // multiplier: operand signs, alignment, one-cycle result
  AST_UNSIGNED_X: assert property (
    !ins.x_signed |-> !xm[16]) else $error("unsigned x operand extended");
  AST_UNSIGNED_Y: assert property (
    !ins.y_signed |-> !ym[16]) else $error("unsigned y operand extended");
  AST_FRAC_ALIGN: assert property (
    !int_mode |-> prod_adj[31:1] == prod[30:0]) else $error("fractional product misaligned");
  AST_MUL_SIGNEXT: assert property (
    (op_mul && !ins.round) |-> mac_res[39:31] == {9{mac_res[31]}})
    else $error("product not sign extended");
  AST_MUL_ONE_CYCLE: assert property (
    (do_op && op_mul && to_mr && !apb_wr) |=> MULT_ACC_OUT == $past(mac_res))
    else $error("product late");

  // shifter and exponent
  AST_LSHIFT_FILL: assert property (
    (ins.op == fpc_pkg::OP_LSHIFT && amt[5]) |-> shift_res[39:16] == 24'h000000)
    else $error("logical shift not zero filled");
  AST_ASHIFT_SIGN: assert property (
    (ins.op == fpc_pkg::OP_ASHIFT && amt[5]) |-> shift_res[39] == xop[15])
    else $error("arithmetic shift lost sign");
  AST_EXP_RANGE: assert property (
    $signed(exp_val) <= 0 && $signed(exp_val) >= -15) else $error("exponent out of range");

  // moves and banks
  AST_MOVE_EXP_IN: assert property (
    (do_op && op_move && ins.exp_to_reg && !ins.exp_sel_shift) |=>
    block_exp_reg[$past(bank_reg)] == $past(xop)) else $error("block exponent not loaded");
  AST_FEEDBACK_SAFE: assert property (
    (do_op && op_move) |=> feedback_reg[$past(bank_reg)] == $past(feedback_reg[bank_reg]))
    else $error("move reached feedback register");
  AST_BANK_SELECT: assert property (
    (apb_wr && PADDR_IN == fpc_pkg::ADDR_BANK) |=> bank_reg == $past(PWDATA_IN[0]))
    else $error("bank select not taken");
  AST_IDLE_BANK: assert property (
    (LOAD_EN_IN && !do_op) |=>
    dreg_reg[$past(other_bank)][$past(LOAD_IDX_IN)] == $past(dreg_reg[other_bank][LOAD_IDX_IN]))
    else $error("load disturbed idle bank");
endmodule : fpc_compute

// ---- tb/fpc_seq_model.sv ----
`timescale 1ns/10ps
module fpc_seq_model (
  // clock
  input wire logic clk_in,
  // instruction and memory load drive
  output fpc_pkg::fpc_instr_t instr_out,
  output logic [15:0] shift_amt_out,
  output logic load_en_out,
  output logic [3:0] load_idx_out,
  output logic [15:0] load_data_out
);
  initial begin
    instr_out = '0;
    shift_amt_out = 16'h0000;
    load_en_out = 1'b0;
    load_idx_out = 4'h0;
    load_data_out = 16'h0000;
  end

  task issue(input fpc_pkg::fpc_instr_t i, input logic [15:0] amt);
    @(posedge clk_in);
    instr_out <= i;
    shift_amt_out <= amt;
  endtask : issue

  task idle();
    @(posedge clk_in);
    instr_out <= '0;
    shift_amt_out <= ~shift_amt_out;
  endtask : idle

  task load(input logic [3:0] idx, input logic [15:0] d);
    @(posedge clk_in);
    load_en_out <= 1'b1;
    load_idx_out <= idx;
    load_data_out <= d;
    @(posedge clk_in);
    load_en_out <= 1'b0;
    // bus released: stale data must not look valid
    load_data_out <= ~d;
  endtask : load
endmodule : fpc_seq_model

// ---- tb/fpc_compute_tb_top.sv ----
`timescale 1ns/10ps
module fpc_compute_tb_top;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic [3:0] rd_idx = 4'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [15:0] rd_data;
  logic [39:0] mult_acc;
  logic [39:0] shift_acc;
  logic illegal;
  fpc_pkg::fpc_instr_t instr;
  logic [15:0] amt;
  logic ld_en;
  logic [3:0] ld_idx;
  logic [15:0] ld_data;
  int n_mismatch = 0;
  int comparisons = 0;
  int cycles = 0;
  logic [31:0] q;
  logic e;
  logic [15:0] v;
  fpc_pkg::fpc_instr_t ins;

  always #5 clk = ~clk;

  fpc_compute dut_u (.CLOCK_IN(clk), .RST_N_IN(rst_n), .INSTR_IN(instr), .SHIFT_AMT_IN(amt),
    .LOAD_IDX_IN(ld_idx), .LOAD_EN_IN(ld_en), .LOAD_DATA_IN(ld_data), .READ_IDX_IN(rd_idx),
    .PSEL_IN(psel), .PENABLE_IN(penable), .PWRITE_IN(pwrite), .PADDR_IN(paddr),
    .PWDATA_IN(pwdata), .PRDATA_OUT(prdata), .PREADY_OUT(pready), .PSLVERR_OUT(pslverr),
    .READ_DATA_OUT(rd_data), .MULT_ACC_OUT(mult_acc), .SHIFT_ACC_OUT(shift_acc),
    .ILLEGAL_OPERAND_OUT(illegal));

  fpc_seq_model seq_u (.clk_in(clk), .instr_out(instr), .shift_amt_out(amt),
    .load_en_out(ld_en), .load_idx_out(ld_idx), .load_data_out(ld_data));

  // ----------------------------------------
  // checking and closing
  // ----------------------------------------
  task stop_test();
    $display("checks %0d, mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : stop_test

  // hang guard, well above the fewer than two hundred cycles the tests need
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      stop_test();
    end
  end

  task chk(input string name, input logic [39:0] seen, input logic [39:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h, seen %h", name, exp, seen);
    end
  endtask : chk

  // ----------------------------------------
  // access tasks
  // ----------------------------------------
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // the wait ends when pready is seen high; only the bench timeout ends one that never sees it
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task rd(input logic [3:0] idx);
    @(posedge clk);
    rd_idx <= idx;
    #1;
    v = rd_data;
  endtask : rd

  function automatic fpc_pkg::fpc_instr_t mk(input fpc_pkg::fpc_op_t op, input logic [3:0] x,
    input logic [3:0] y, input fpc_pkg::fpc_dst_t dst);
    fpc_pkg::fpc_instr_t i;
    i = '0;
    i.valid = 1'b1;
    i.op = op;
    i.x_idx = x;
    i.y_idx = y;
    i.dst = dst;
    return i;
  endfunction : mk

  task alu_case(input fpc_pkg::fpc_op_t op, input logic [3:0] x, input logic [3:0] y,
    input logic [15:0] ar, input logic [7:0] fl, input logic [7:0] mask);
    seq_u.issue(mk(op, x, y, fpc_pkg::DST_ALU_RESULT), 16'h0000);
    seq_u.idle();
    rd(fpc_pkg::REG_AR_IDX);
    chk("alu result", {24'h0, v}, {24'h0, ar});
    apb(1'b0, fpc_pkg::ADDR_FLAGS, 32'h0);
    chk("alu flags", {32'h0, q[7:0] & mask}, {32'h0, fl});
  endtask : alu_case

  task mul_case(input logic [3:0] x, input logic [3:0] y, input logic xs, input logic ys,
    input logic [7:0] mode, input logic [39:0] exp);
    apb(1'b1, fpc_pkg::ADDR_MODE, {24'h0, mode});
    ins = mk(fpc_pkg::OP_MUL, x, y, fpc_pkg::DST_MULT_ACC);
    ins.x_signed = xs;
    ins.y_signed = ys;
    seq_u.issue(ins, 16'h0000);
    seq_u.idle();
    #1;
    chk("product", mult_acc, exp);
  endtask : mul_case

  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    apb(1'b0, fpc_pkg::ADDR_MODE, 32'h0);
    chk("mode reset", {8'h0, q}, 40'h0);
    apb(1'b1, fpc_pkg::ADDR_FLAGS, 32'h000000FF);
    apb(1'b0, fpc_pkg::ADDR_FLAGS, 32'h0);
    chk("flags read only", {8'h0, q}, 40'h0);
    apb(1'b0, 8'h40, 32'h0);
    chk("unmapped error", {39'h0, e}, 40'h1);
    $display("test registers done");
    seq_u.load(4'h0, 16'h7FFF);
    seq_u.load(4'h1, 16'h0001);
    seq_u.load(4'h2, 16'hFFFF);
    seq_u.load(4'h3, 16'hF0F0);
    seq_u.load(4'h4, 16'hFF00);
    seq_u.load(4'h5, 16'h4000);
    seq_u.load(4'h6, 16'h8000);
    alu_case(fpc_pkg::OP_ADD, 4'h0, 4'h1, 16'h8000, 8'h06, 8'h0F);
    alu_case(fpc_pkg::OP_ADD, 4'h2, 4'h1, 16'h0000, 8'h09, 8'h0F);
    alu_case(fpc_pkg::OP_ADD, 4'h0, 4'h2, 16'h7FFE, 8'h08, 8'h0F);
    alu_case(fpc_pkg::OP_AND, 4'h3, 4'h4, 16'hF000, 8'h02, 8'h03);
    alu_case(fpc_pkg::OP_OR, 4'h3, 4'h4, 16'hFFF0, 8'h02, 8'h03);
    alu_case(fpc_pkg::OP_XOR, 4'h3, 4'h4, 16'h0FF0, 8'h00, 8'h03);
    alu_case(fpc_pkg::OP_NOT, 4'h3, 4'h4, 16'h0F0F, 8'h00, 8'h03);
    alu_case(fpc_pkg::OP_SUB, 4'h6, 4'h1, 16'h7FFF, 8'h04, 8'h07);
    $display("test alu done");
    seq_u.issue(mk(fpc_pkg::OP_ADD, 4'h0, 4'h1, fpc_pkg::DST_ALU_RESULT), 16'h0000);
    seq_u.issue(mk(fpc_pkg::OP_ADD, 4'h9, 4'h1, fpc_pkg::DST_ALU_RESULT), 16'h0000);
    seq_u.idle();
    rd(fpc_pkg::REG_AR_IDX);
    chk("chained result", {24'h0, v}, 40'h8001);
    ins = mk(fpc_pkg::OP_ADD, 4'h9, 4'h1, fpc_pkg::DST_ALU_RESULT);
    ins.conditional = 1'b1;
    seq_u.issue(ins, 16'h0000);
    #1;
    chk("restricted operand", {39'h0, illegal}, 40'h1);
    seq_u.idle();
    rd(fpc_pkg::REG_AR_IDX);
    chk("dropped op", {24'h0, v}, 40'h8001);
    $display("test access done");
    mul_case(4'h5, 4'h5, 1'b1, 1'b1, 8'h00, 40'h0020000000);
    mul_case(4'h2, 4'h1, 1'b1, 1'b1, 8'h00, 40'hFFFFFFFFFE);
    mul_case(4'h5, 4'h5, 1'b1, 1'b1, 8'h10, 40'h0010000000);
    mul_case(4'h2, 4'h1, 1'b1, 1'b1, 8'h10, 40'hFFFFFFFFFF);
    rd(fpc_pkg::REG_MR2_IDX);
    chk("upper word", {24'h0, v}, 40'hFFFF);
    mul_case(4'h2, 4'h2, 1'b0, 1'b0, 8'h10, 40'hFFFFFE0001);
    mul_case(4'h2, 4'h2, 1'b1, 1'b0, 8'h10, 40'hFFFFFF0001);
    $display("test multiplier done");
    seq_u.issue(mk(fpc_pkg::OP_LSHIFT, 4'h6, 4'h0, fpc_pkg::DST_SHIFT_ACC), 16'hFFFF);
    seq_u.idle();
    #1;
    chk("logical shift", {24'h0, shift_acc[15:0]}, 40'h4000);
    seq_u.issue(mk(fpc_pkg::OP_ASHIFT, 4'h6, 4'h0, fpc_pkg::DST_SHIFT_ACC), 16'hFFFF);
    seq_u.idle();
    #1;
    chk("arith shift", {24'h0, shift_acc[15:0]}, 40'hC000);
    $display("test shifter done");
    // block exponent is loaded by a register move, read back by a move and over APB
    ins = mk(fpc_pkg::OP_MOVE, 4'h5, 4'h0, fpc_pkg::DST_ALU_RESULT);
    ins.exp_to_reg = 1'b1;
    seq_u.issue(ins, 16'h0000);
    ins = mk(fpc_pkg::OP_MOVE_EXP, 4'h0, 4'h0, fpc_pkg::DST_ALU_RESULT);
    ins.move_dst_idx = 4'h7;
    seq_u.issue(ins, 16'h0000);
    seq_u.idle();
    apb(1'b0, fpc_pkg::ADDR_BLOCK_EXP, 32'h0);
    chk("block exponent", {8'h0, q}, 40'h4000);
    rd(4'h7);
    chk("exponent readback", {24'h0, v}, 40'h4000);
    apb(1'b1, fpc_pkg::ADDR_BANK, 32'h00000001);
    seq_u.load(4'h0, 16'h1234);
    rd(4'h0);
    chk("alternate bank", {24'h0, v}, 40'h1234);
    apb(1'b1, fpc_pkg::ADDR_BANK, 32'h00000000);
    rd(4'h0);
    chk("primary bank kept", {24'h0, v}, 40'h7FFF);
    $display("test banks done");
    stop_test();
  end
endmodule : fpc_compute_tb_top
